// ===== core/acs_pkg.sv
// Purpose: Shared constants for the calibration reset sequencer link
// Assumes: One 20 MHz clock stands in for the sample clock
// Notes: Times kept in their own unit with derived cycle counts

package acs_pkg;

  // ----------------------------------------
  // Clock and timing
  // ----------------------------------------
  localparam int unsigned CLK_PERIOD_NS = 50;
  localparam int unsigned SPI_REF_PERIOD_NS = 16;
  localparam int unsigned CAL_NOM_MS = 560;
  localparam int unsigned CAL_MAX_MS = 1000;
  localparam int unsigned CAL_NOM_CYC = (CAL_NOM_MS * 1000000) / CLK_PERIOD_NS;
  localparam int unsigned CAL_MAX_CYC = (CAL_MAX_MS * 1000000) / CLK_PERIOD_NS;
  localparam int unsigned PIPE_LATENCY = 10;
  localparam int unsigned RECAL_LOW_MIN_CYC = 1;

  // ----------------------------------------
  // Serial port scaling (cycles at ref period)
  // ----------------------------------------
  localparam int unsigned SPI_CLK_CYC_REF = 16;
  localparam int unsigned SPI_CLK_CYC = (SPI_CLK_CYC_REF * SPI_REF_PERIOD_NS +
                                         CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  // ----------------------------------------
  // Registers and data
  // ----------------------------------------
  localparam int unsigned DATA_W = 16;
  localparam int unsigned ADDR_W = 8;
  localparam logic [7:0] CAL_STATUS_ADDR = 8'hB6;
  localparam int unsigned CAL_DONE_BIT = 0;
  localparam logic [7:0] CAL_STATUS_RESET = 8'h00;
  localparam logic [15:0] CAL_PATTERN = 16'hCCCC;
  localparam logic [7:0] UNMAPPED_READ = 8'h00;
  localparam int unsigned CNT_W = 32;

  typedef enum logic [1:0] {
    ACS_POR = 2'b00,
    ACS_HOLD = 2'b01,
    ACS_CAL = 2'b10,
    ACS_RUN = 2'b11
  } acs_state_t;

endpackage

// ===== core/acs_link_if.sv
// Purpose: Pins between converter and system controller
// Assumes: Open-drain recal line and pulled-up serial data out
// Notes: Wire levels resolved here from the enables

`timescale 1ns/10ps

interface acs_link_if;
  // Recal line, open drain, active-low enables
  logic recal_dev_oe_n;
  logic recal_ctl_oe_n;
  logic recal_request_low;
  // Serial port
  logic spi_cs_n;
  logic spi_sclk;
  logic spi_sdi;
  logic spi_sdo_o;
  logic spi_sdo_oe_n;
  logic spi_sdo;
  // Output data and clock
  logic output_clock_pair;
  logic [15:0] data_out;

  // Low when either end drives, pulled high otherwise
  assign recal_request_low = recal_dev_oe_n & recal_ctl_oe_n;
  assign spi_sdo = spi_sdo_oe_n ? 1'b1 : spi_sdo_o;

  modport device (
    output recal_dev_oe_n,
    input recal_request_low,
    input spi_cs_n,
    input spi_sclk,
    input spi_sdi,
    output spi_sdo_o,
    output spi_sdo_oe_n,
    output output_clock_pair,
    output data_out
  );

  modport ctrl (
    output recal_ctl_oe_n,
    input recal_request_low,
    output spi_cs_n,
    output spi_sclk,
    output spi_sdi,
    input spi_sdo,
    input output_clock_pair,
    input data_out
  );
endinterface

// ===== core/acs_device.sv
// Purpose: Converter end: power-on hold, calibration, status, outputs
// Assumes: clock_i is the sample clock; serial pins are asynchronous
// Notes: Serial frame is 1 rw bit, 8 address bits, 8 data bits

`timescale 1ns/10ps

module acs_device
  import acs_pkg::*;
#(
  parameter int unsigned CAL_CYCLES = acs_pkg::CAL_NOM_CYC,
  parameter int unsigned POR_CYCLES = 16
) (
  // Clock and reset
  input wire logic clock_i,
  input wire logic reset_n_i,
  // Link
  acs_link_if.device link,
  // Converter core side
  input wire logic [acs_pkg::DATA_W-1:0] sample_i,
  output logic cal_done_o,
  output logic [acs_pkg::DATA_W-1:0] sample_o
);
  import acs_pkg::*;

  // ----------------------------------------
  // Input synchronisers
  // ----------------------------------------
  logic [1:0] recal_sync_r;
  logic [1:0] cs_sync_r;
  logic [1:0] sclk_sync_r;
  logic [1:0] sdi_sync_r;
  logic recal_q_r;
  logic sclk_q_r;

  always_ff @(posedge clock_i) begin
    if (!reset_n_i) begin
      recal_sync_r <= 2'h0;
      cs_sync_r <= 2'h3;
      sclk_sync_r <= 2'h0;
      sdi_sync_r <= 2'h0;
      recal_q_r <= 1'b0;
      sclk_q_r <= 1'b0;
    end else begin
      recal_sync_r <= {recal_sync_r[0], link.recal_request_low};
      cs_sync_r <= {cs_sync_r[0], link.spi_cs_n};
      sclk_sync_r <= {sclk_sync_r[0], link.spi_sclk};
      sdi_sync_r <= {sdi_sync_r[0], link.spi_sdi};
      recal_q_r <= recal_sync_r[1];
      sclk_q_r <= sclk_sync_r[1];
    end
  end

  logic recal_rise;
  logic sclk_rise;
  logic sclk_fall;
  assign recal_rise = recal_sync_r[1] & ~recal_q_r;
  assign sclk_rise = sclk_sync_r[1] & ~sclk_q_r;
  assign sclk_fall = ~sclk_sync_r[1] & sclk_q_r;

  // ----------------------------------------
  // Sequencer
  // ----------------------------------------
  acs_state_t state_r;
  logic [CNT_W-1:0] cnt_r;

  always_ff @(posedge clock_i) begin
    if (!reset_n_i) begin
      state_r <= ACS_POR;
      cnt_r <= '0;
    end else begin
      case (state_r)
        ACS_POR: begin
          if (cnt_r >= CNT_W'(POR_CYCLES - 1)) begin
            state_r <= ACS_HOLD;
            cnt_r <= '0;
          end else begin
            cnt_r <= cnt_r + 1'b1;
          end
        end
        ACS_HOLD, ACS_RUN: begin
          if (recal_rise) begin
            state_r <= ACS_CAL;
            cnt_r <= '0;
          end
        end
        ACS_CAL: begin
          if (recal_rise) begin
            cnt_r <= '0;
          end else if (cnt_r >= CNT_W'(CAL_CYCLES - 1)) begin
            state_r <= ACS_RUN;
            cnt_r <= '0;
          end else begin
            cnt_r <= cnt_r + 1'b1;
          end
        end
        default: begin
          state_r <= ACS_POR;
          cnt_r <= '0;
        end
      endcase
    end
  end

  logic calibrating;
  assign calibrating = (state_r != ACS_RUN);
  assign link.recal_dev_oe_n = (state_r != ACS_POR);

  // ----------------------------------------
  // Status register
  // ----------------------------------------
  logic [7:0] cal_status_r;

  always_ff @(posedge clock_i) begin
    if (!reset_n_i) begin
      cal_status_r <= CAL_STATUS_RESET;
    end else begin
      cal_status_r[CAL_DONE_BIT] <= ~calibrating & ~recal_rise;
    end
  end
  assign cal_done_o = cal_status_r[CAL_DONE_BIT];

  // ----------------------------------------
  // Pipeline and outputs
  // ----------------------------------------
  logic [DATA_W-1:0] pipe_r [PIPE_LATENCY];
  logic [DATA_W-1:0] dout_r;
  logic clkout_r;

  genvar gi;
  generate
    for (gi = 0; gi < PIPE_LATENCY; gi++) begin : g_pipe
      if (gi == 0) begin : g_first
        always_ff @(posedge clock_i) begin
          if (!reset_n_i) begin
            pipe_r[gi] <= '0;
          end else begin
            pipe_r[gi] <= sample_i;
          end
        end
      end else begin : g_next
        always_ff @(posedge clock_i) begin
          if (!reset_n_i) begin
            pipe_r[gi] <= '0;
          end else begin
            pipe_r[gi] <= pipe_r[gi-1];
          end
        end
      end
    end
  endgenerate

  always_ff @(posedge clock_i) begin
    if (!reset_n_i) begin
      dout_r <= CAL_PATTERN;
      clkout_r <= 1'b0;
    end else begin
      // Pattern from the same edge that clears the done flag
      dout_r <= (calibrating || recal_rise) ? CAL_PATTERN : pipe_r[PIPE_LATENCY-1];
      if (!recal_sync_r[1]) begin
        clkout_r <= 1'b0;
      end else begin
        clkout_r <= ~clkout_r;
      end
    end
  end
  assign link.output_clock_pair = clkout_r;
  assign sample_o = dout_r;
  assign link.data_out = dout_r;

  // ----------------------------------------
  // Serial port
  // ----------------------------------------
  logic [4:0] bit_cnt_r;
  logic [8:0] hdr_r;
  logic [7:0] rd_sh_r;
  logic sdo_oe_n_r;

  always_ff @(posedge clock_i) begin
    if (!reset_n_i) begin
      bit_cnt_r <= 5'h00;
      hdr_r <= 9'h000;
      rd_sh_r <= 8'h00;
      sdo_oe_n_r <= 1'b1;
    end else if (cs_sync_r[1]) begin
      bit_cnt_r <= 5'h00;
      sdo_oe_n_r <= 1'b1;
    end else if (sclk_rise && bit_cnt_r < 5'd9) begin
      hdr_r <= {hdr_r[7:0], sdi_sync_r[1]};
      bit_cnt_r <= bit_cnt_r + 5'd1;
      if (bit_cnt_r == 5'd8) begin
        rd_sh_r <= ({hdr_r[6:0], sdi_sync_r[1]} == CAL_STATUS_ADDR) ?
                   cal_status_r : UNMAPPED_READ;
      end
    end else if (sclk_fall && bit_cnt_r >= 5'd9 && bit_cnt_r < 5'd17) begin
      sdo_oe_n_r <= ~hdr_r[8];
      if (bit_cnt_r != 5'd9) begin
        rd_sh_r <= {rd_sh_r[6:0], 1'b0};
      end
      bit_cnt_r <= bit_cnt_r + 5'd1;
    end
  end
  assign link.spi_sdo_o = rd_sh_r[7];
  assign link.spi_sdo_oe_n = sdo_oe_n_r;

endmodule // acs_device

// ===== core/acs_ctrl.sv
// Purpose: Controller end: recal pulse and status read over serial
// Assumes: Same clock as device; serial clock derived by divider
// Notes: Serial half period is SPI_CLK_CYC_REF cycles, not scaled from reference limits

`timescale 1ns/10ps

module acs_ctrl
  import acs_pkg::*;
(
  // Clock and reset
  input wire logic clock_i,
  input wire logic reset_n_i,
  // Link
  acs_link_if.ctrl link,
  // User side
  input wire logic recal_req_i,
  input wire logic rd_req_i,
  output logic busy_o,
  output logic rd_valid_o,
  output logic [7:0] rd_data_o
);
  import acs_pkg::*;

  // ----------------------------------------
  // Recalibration pulse
  // ----------------------------------------
  logic [7:0] low_cnt_r;
  always_ff @(posedge clock_i) begin
    if (!reset_n_i) begin
      low_cnt_r <= 8'h00;
    end else if (recal_req_i && low_cnt_r == 8'h00) begin
      low_cnt_r <= 8'(RECAL_LOW_MIN_CYC + 1);
    end else if (low_cnt_r != 8'h00) begin
      low_cnt_r <= low_cnt_r - 8'h01;
    end
  end
  assign link.recal_ctl_oe_n = (low_cnt_r == 8'h00);

  // ----------------------------------------
  // Serial read of status
  // ----------------------------------------
  logic [1:0] done_sync_r;
  logic [7:0] div_r;
  logic [5:0] ph_r;
  logic active_r;
  logic cs_n_r;
  logic sclk_r;
  logic sdi_r;
  logic [16:0] tx_r;
  logic [7:0] rx_r;
  logic rd_valid_r;
  logic sdo_s1_r;
  logic sdo_s2_r;
  // Limits count sample cycles, so one half period per serial period count
  localparam logic [7:0] HALF = 8'(SPI_CLK_CYC_REF - 1);

  always_ff @(posedge clock_i) begin
    if (!reset_n_i) begin
      sdo_s1_r <= 1'b1;
      sdo_s2_r <= 1'b1;
    end else begin
      sdo_s1_r <= link.spi_sdo;
      sdo_s2_r <= sdo_s1_r;
    end
  end

  always_ff @(posedge clock_i) begin
    if (!reset_n_i) begin
      active_r <= 1'b0;
      div_r <= 8'h00;
      ph_r <= 6'h00;
      cs_n_r <= 1'b1;
      sclk_r <= 1'b0;
      sdi_r <= 1'b0;
      tx_r <= 17'h00000;
      rx_r <= 8'h00;
      rd_valid_r <= 1'b0;
    end else begin
      rd_valid_r <= 1'b0;
      if (!active_r) begin
        if (rd_req_i && link.recal_request_low && low_cnt_r == 8'h00) begin
          active_r <= 1'b1;
          tx_r <= {1'b1, CAL_STATUS_ADDR, 8'h00};
          cs_n_r <= 1'b0;
          div_r <= 8'h00;
          ph_r <= 6'h00;
        end
      end else if (div_r != HALF) begin
        div_r <= div_r + 8'h01;
      end else begin
        div_r <= 8'h00;
        ph_r <= ph_r + 6'h01;
        if (ph_r == 6'd34) begin
          rx_r <= {rx_r[6:0], sdo_s2_r};
          cs_n_r <= 1'b1;
          active_r <= 1'b0;
          rd_valid_r <= 1'b1;
        end else if (!ph_r[0]) begin
          sdi_r <= tx_r[16];
          tx_r <= {tx_r[15:0], 1'b0};
          sclk_r <= 1'b0;
          if (ph_r >= 6'd20) begin
            rx_r <= {rx_r[6:0], sdo_s2_r};
          end
        end else begin
          sclk_r <= 1'b1;
        end
      end
    end
  end

  assign link.spi_cs_n = cs_n_r;
  assign link.spi_sclk = sclk_r;
  assign link.spi_sdi = sdi_r;
  assign busy_o = active_r | (low_cnt_r != 8'h00);
  assign rd_valid_o = rd_valid_r;
  assign rd_data_o = rx_r;

endmodule // acs_ctrl

// ===== bench/acs_checker.sv
// Purpose: Link assertions for the calibration sequencer pair
// Assumes: One clock, synchronous active-low reset
// Notes: Bench runs with a shortened calibration count

`timescale 1ns/10ps

module acs_checker
  import acs_pkg::*;
(
  // Clock and reset
  input wire logic clock_i,
  input wire logic reset_n_i,
  // Link signals
  input wire logic recal_dev_oe_n,
  input wire logic recal_ctl_oe_n,
  input wire logic recal_request_low,
  input wire logic spi_cs_n,
  input wire logic output_clock_pair,
  input wire logic [15:0] data_out
);
  import acs_pkg::*;

  // ----------------------------------------
  // Sequences
  // ----------------------------------------
  default clocking cb @(posedge clock_i); endclocking
  default disable iff (!reset_n_i);
  sequence s_por_hold;
    (!recal_dev_oe_n)[*3] ##[1:6] recal_dev_oe_n;
  endsequence
  sequence s_pattern;
    (data_out == CAL_PATTERN)[*8];
  endsequence

  // ----------------------------------------
  // Properties
  // ----------------------------------------
  property p_por_hold;
    $rose(reset_n_i) |-> s_por_hold;
  endproperty
  property p_dev_release;
    $rose(recal_dev_oe_n) |-> recal_dev_oe_n[*8];
  endproperty
  property p_cal_start;
    $rose(recal_request_low) && data_out != CAL_PATTERN |-> ##[1:6] data_out == CAL_PATTERN;
  endproperty
  property p_cal_pattern;
    $rose(recal_request_low) |-> ##6 s_pattern;
  endproperty
  property p_clk_low;
    !recal_request_low |-> ##3 !output_clock_pair;
  endproperty
  property p_clk_run;
    recal_request_low[*6] |-> output_clock_pair != $past(output_clock_pair);
  endproperty
  property p_ctl_pulse;
    $fell(recal_ctl_oe_n) |-> ##[1:16] recal_ctl_oe_n;
  endproperty
  property p_no_spi;
    !recal_request_low |-> spi_cs_n;
  endproperty

  a_por_hold: assert property (p_por_hold) else $error("power-on hold wrong");
  a_dev_release: assert property (p_dev_release) else $error("device drove line");
  a_cal_start: assert property (p_cal_start) else $error("calibration not begun");
  a_cal_pattern: assert property (p_cal_pattern) else $error("pattern missing");
  a_clk_low: assert property (p_clk_low) else $error("clock not low");
  a_clk_run: assert property (p_clk_run) else $error("clock not toggling");
  a_ctl_pulse: assert property (p_ctl_pulse) else $error("pulse not released");
  a_no_spi: assert property (p_no_spi) else $error("serial during reset");
endmodule // acs_checker

// ===== bench/tb.sv
// Purpose: Self-checking bench for both link ends
// Assumes: Calibration shortened to 200 cycles, power-on hold 4
// Notes: Inputs change at the falling edge

`timescale 1ns/10ps

module tb;
  import acs_pkg::*;
  // ----------------------------------------
  // Signals and instances
  // ----------------------------------------
  localparam int CALC = 200;
  logic clock_i = 1'b0;
  logic reset_n_i = 1'b0;
  logic recal_req_i = 1'b0;
  logic rd_req_i = 1'b0;
  logic [15:0] sample_i = 16'h0000;
  logic cal_done;
  logic busy;
  logic rd_valid;
  logic [15:0] sample_o;
  logic [7:0] rd_data;
  int err_total = 0;
  int check_count = 0;

  acs_link_if i_acs_link_if();
  acs_device #(.CAL_CYCLES(CALC), .POR_CYCLES(4)) i_acs_device (.clock_i(clock_i),
    .reset_n_i(reset_n_i), .link(i_acs_link_if.device), .sample_i(sample_i),
    .cal_done_o(cal_done), .sample_o(sample_o));
  acs_ctrl i_acs_ctrl (.clock_i(clock_i), .reset_n_i(reset_n_i), .link(i_acs_link_if.ctrl),
    .recal_req_i(recal_req_i), .rd_req_i(rd_req_i), .busy_o(busy), .rd_valid_o(rd_valid),
    .rd_data_o(rd_data));
  acs_checker i_acs_checker (.clock_i(clock_i), .reset_n_i(reset_n_i),
    .recal_dev_oe_n(i_acs_link_if.recal_dev_oe_n),
    .recal_ctl_oe_n(i_acs_link_if.recal_ctl_oe_n),
    .recal_request_low(i_acs_link_if.recal_request_low), .spi_cs_n(i_acs_link_if.spi_cs_n),
    .output_clock_pair(i_acs_link_if.output_clock_pair), .data_out(i_acs_link_if.data_out));

  initial begin
    forever #25 clock_i = ~clock_i;
  end
  always @(negedge clock_i) begin
    sample_i <= sample_i + 16'h0001;
  end

  // ----------------------------------------
  // Tasks
  // ----------------------------------------
  task automatic print_verdict();
    if (err_total == 0 && check_count > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask

  task automatic chk(input string nm, input logic [15:0] exp, input logic [15:0] got);
    check_count++;
    if (got !== exp) begin
      $display("FAIL %s exp %h got %h", nm, exp, got);
      err_total++;
    end
  endtask

  task automatic wait_done(input logic exp, input int lo, input int hi);
    int n;
    n = 0;
    while (cal_done !== exp && n < hi) begin
      @(negedge clock_i);
      n++;
    end
    chk("cal_done_time", 16'h0001, 16'(n >= lo && n < hi));
    if (n >= hi) begin
      print_verdict();
    end
  endtask

  task automatic rd_status(input logic [7:0] exp);
    int n;
    n = 0;
    chk("busy", 16'h0000, 16'(busy));
    rd_req_i = 1'b1;
    @(negedge clock_i);
    rd_req_i = 1'b0;
    while (rd_valid !== 1'b1 && n < 2000) begin
      @(negedge clock_i);
      n++;
    end
    chk("rd_timeout", 16'h0000, 16'(n >= 2000));
    chk("status", 16'(exp), 16'(rd_data));
    if (n >= 2000) begin
      print_verdict();
    end
  endtask

  task automatic recal();
    recal_req_i = 1'b1;
    @(negedge clock_i);
    recal_req_i = 1'b0;
  endtask

  task automatic power_up();
    reset_n_i = 1'b0;
    repeat (16) @(negedge clock_i);
    chk("done_rst", 16'h0000, 16'(cal_done));
    chk("data_rst", CAL_PATTERN, i_acs_link_if.data_out);
    reset_n_i = 1'b1;
    wait_done(1'b1, CALC, CALC + 40);
    rd_status(8'h01);
  endtask

  // ----------------------------------------
  // Main sequence
  // ----------------------------------------
  initial begin
    power_up();
    repeat (20) @(negedge clock_i);
    chk("latency", sample_i - 16'h000A, i_acs_link_if.data_out);
    chk("sample_o", sample_i - 16'h000A, sample_o);
    recal();
    wait_done(1'b0, 0, 20);
    chk("data_cal", CAL_PATTERN, i_acs_link_if.data_out);
    repeat (50) @(negedge clock_i);
    recal();
    wait_done(1'b1, CALC, CALC + 60);
    rd_status(8'h01);
    repeat (12) @(negedge clock_i);
    chk("latency2", sample_i - 16'h000A, i_acs_link_if.data_out);
    power_up();
    print_verdict();
  end
endmodule // tb
